// ===== design/dcdll_core.sv
`timescale 1ns/100ps
module dcdll_core
  import dcdll_pkg::*;
(
  // Clock and reset
  input  wire logic       mclk,
  input  wire logic       nrst,
  // Register port
  input  wire logic [11:0] reg_addr,
  input  wire logic [7:0]  reg_wdata,
  input  wire logic        reg_wr,
  output logic [7:0]       reg_rdata,
  // Phase detector
  input  wire logic [4:0]  phase_meas,
  // Delay line and clock controls
  output logic [5:0]       coarse_delay,
  output logic [7:0]       fine_delay,
  output logic             invert_core_clock,
  output logic             core_clock_duty_correct,
  output logic             core_clock_cross_ctrl,
  output logic             core_clk_out,
  output logic             test_clk_out,
  output logic             loop_locked_flag
);

  logic        loop_en_q;
  logic [5:0]  coarse_set_q;
  logic [7:0]  fine_set_q;
  logic [4:0]  phase_target_q;
  logic [2:0]  phase_filter_bandwidth_q;
  logic [1:0]  tracking_speed_q;
  logic        snap_req_q;
  logic [5:0]  coarse_delay_snapshot_q;
  logic [7:0]  fine_delay_snapshot_q;
  logic [4:0]  phase_snapshot_q;
  logic [2:0]  clk_shape_q;
  logic        test_en_q;
  logic [1:0]  test_div_q;
  logic [7:0]  fine_live_q;
  logic [4:0]  phase_filt_q;
  logic [7:0]  tick_cnt_q;
  logic        tick;
  logic [3:0]  hold_cnt_q;
  logic        locked_q;
  logic [3:0]  div_cnt_q;
  logic        core_tgl_q;
  logic        test_clk_q;
  dcdll_state_t state_q;

  function automatic logic hit(input logic [11:0] ofs);
    return reg_wr && (reg_addr == ofs);
  endfunction

  function automatic logic [4:0] clamp_phase(input logic [4:0] v);
    return (v > PHASE_MAX) ? PHASE_MAX : v;
  endfunction

  // Writable controls
  always_ff @(posedge mclk) begin
    if (!nrst) begin
      loop_en_q                <= 1'b0;
      coarse_set_q             <= 6'h00;
      fine_set_q               <= FINE_SET_RST;
      phase_target_q           <= PHASE_TGT_RST;
      phase_filter_bandwidth_q <= 3'h0;
      tracking_speed_q         <= 2'h0;
      clk_shape_q              <= CLK_SHAPE_RST;
      test_en_q                <= 1'b0;
      test_div_q               <= 2'h0;
    end else begin
      if (hit(LOOP_CTRL_OFS)) begin
        loop_en_q <= reg_wdata[0];
      end
      if (hit(COARSE_SET_OFS)) begin
        coarse_set_q <= reg_wdata[5:0];
      end
      if (hit(FINE_SET_OFS)) begin
        fine_set_q <= reg_wdata;
      end
      if (hit(PHASE_TGT_OFS)) begin
        phase_target_q <= clamp_phase(reg_wdata[4:0]);
      end
      if (hit(BANDWIDTH_OFS)) begin
        phase_filter_bandwidth_q <= reg_wdata[BW_FILT_LSB +: 3];
        tracking_speed_q         <= reg_wdata[1:0];
      end
      if (hit(CLK_SHAPE_OFS)) begin
        clk_shape_q <= reg_wdata[2:0];
      end
      if (hit(TEST_CLK_OFS)) begin
        test_en_q  <= reg_wdata[TEST_EN_BIT];
        test_div_q <= reg_wdata[1:0];
      end
    end
  end

  // Snapshot capture on a rising request
  always_ff @(posedge mclk) begin
    if (!nrst) begin
      snap_req_q              <= 1'b0;
      coarse_delay_snapshot_q <= 6'h00;
      fine_delay_snapshot_q   <= 8'h00;
      phase_snapshot_q        <= 5'h00;
    end else if (hit(SNAP_REQ_OFS)) begin
      snap_req_q <= reg_wdata[0];
      if (reg_wdata[0] && !snap_req_q) begin
        coarse_delay_snapshot_q <= coarse_delay;
        fine_delay_snapshot_q   <= fine_delay;
        phase_snapshot_q        <= phase_filt_q;
      end
    end
  end

  // Tracking tick from tracking speed
  always_ff @(posedge mclk) begin
    if (!nrst || tick) begin
      tick_cnt_q <= 8'h00;
    end else begin
      tick_cnt_q <= tick_cnt_q + 8'h01;
    end
  end
  assign tick = (tick_cnt_q >= ((TRACK_BASE_CYCLES << tracking_speed_q) - 8'h01));

  // Phase measurement filter
  always_ff @(posedge mclk) begin
    if (!nrst) begin
      phase_filt_q <= 5'h00;
    end else if (phase_filter_bandwidth_q == 3'h0) begin
      phase_filt_q <= phase_meas;
    end else if (tick) begin
      phase_filt_q <= phase_filt_q + 5'($signed(6'(phase_meas) - 6'(phase_filt_q))
                      >>> phase_filter_bandwidth_q);
    end
  end

  // Loop controller
  always_ff @(posedge mclk) begin
    if (!nrst) begin
      state_q     <= DCDLL_OPEN;
      fine_live_q <= FINE_SET_RST;
      hold_cnt_q  <= 4'h0;
      locked_q    <= 1'b0;
    end else begin
      case (state_q)
        DCDLL_OPEN: begin
          fine_live_q <= fine_set_q;
          hold_cnt_q  <= 4'h0;
          locked_q    <= 1'b0;
          if (loop_en_q) begin
            state_q <= DCDLL_TRACK;
          end
        end
        DCDLL_TRACK: begin
          if (!loop_en_q) begin
            state_q <= DCDLL_OPEN;
          end else if (tick) begin
            if (phase_filt_q < phase_target_q) begin
              fine_live_q <= (fine_live_q == 8'hff) ? fine_live_q : fine_live_q + 8'h01;
              hold_cnt_q  <= 4'h0;
            end else if (phase_filt_q > phase_target_q) begin
              fine_live_q <= (fine_live_q == 8'h00) ? fine_live_q : fine_live_q - 8'h01;
              hold_cnt_q  <= 4'h0;
            end else if (hold_cnt_q == LOCK_HOLD_TICKS - 4'h1) begin
              locked_q <= 1'b1;
              state_q  <= DCDLL_LOCK;
            end else begin
              hold_cnt_q <= hold_cnt_q + 4'h1;
            end
          end
        end
        DCDLL_LOCK: begin
          if (!loop_en_q) begin
            state_q  <= DCDLL_OPEN;
            locked_q <= 1'b0;
          end else if (tick && phase_filt_q != phase_target_q) begin
            fine_live_q <= (phase_filt_q < phase_target_q) ?
                           ((fine_live_q == 8'hff) ? fine_live_q : fine_live_q + 8'h01) :
                           ((fine_live_q == 8'h00) ? fine_live_q : fine_live_q - 8'h01);
          end
        end
        default: begin
          state_q <= DCDLL_OPEN;
        end
      endcase
    end
  end

  // Clock generation and test divider
  always_ff @(posedge mclk) begin
    if (!nrst) begin
      div_cnt_q  <= 4'h0;
      core_tgl_q <= 1'b0;
      test_clk_q <= 1'b0;
    end else begin
      div_cnt_q  <= div_cnt_q + 4'h1;
      core_tgl_q <= ~core_tgl_q;
      test_clk_q <= test_en_q & div_cnt_q[test_div_q];
    end
  end

  assign coarse_delay            = coarse_set_q;
  assign fine_delay              = fine_live_q;
  assign invert_core_clock       = clk_shape_q[INVERT_BIT];
  assign core_clock_duty_correct = clk_shape_q[DUTY_BIT];
  assign core_clock_cross_ctrl   = clk_shape_q[CROSS_BIT];
  assign core_clk_out            = core_tgl_q ^ clk_shape_q[INVERT_BIT];
  assign test_clk_out            = test_clk_q;
  assign loop_locked_flag        = locked_q;

  // Register readback
  always_comb begin
    reg_rdata = 8'h00;
    if (reg_addr == LOOP_CTRL_OFS) begin
      reg_rdata = {7'h00, loop_en_q};
    end else if (reg_addr == LOOP_STATUS_OFS) begin
      reg_rdata = {7'h00, locked_q};
    end else if (reg_addr == COARSE_SET_OFS) begin
      reg_rdata = {2'h0, coarse_set_q};
    end else if (reg_addr == FINE_SET_OFS) begin
      reg_rdata = fine_set_q;
    end else if (reg_addr == PHASE_TGT_OFS) begin
      reg_rdata = {3'h0, phase_target_q};
    end else if (reg_addr == BANDWIDTH_OFS) begin
      reg_rdata = {3'h0, phase_filter_bandwidth_q, tracking_speed_q};
    end else if (reg_addr == SNAP_REQ_OFS) begin
      reg_rdata = {7'h00, snap_req_q};
    end else if (reg_addr == COARSE_SNAP_OFS) begin
      reg_rdata = {2'h0, coarse_delay_snapshot_q};
    end else if (reg_addr == FINE_SNAP_OFS) begin
      reg_rdata = fine_delay_snapshot_q;
    end else if (reg_addr == PHASE_SNAP_OFS) begin
      reg_rdata = {3'h0, phase_snapshot_q};
    end else if (reg_addr == CLK_SHAPE_OFS) begin
      reg_rdata = {5'h00, clk_shape_q};
    end else if (reg_addr == TEST_CLK_OFS) begin
      reg_rdata = {test_en_q, 5'h00, test_div_q};
    end
  end

  default clocking cb @(posedge mclk); endclocking
  default disable iff (!nrst);

  a_fine_static_set: assert property (
    (state_q == DCDLL_OPEN) ##1 (state_q == DCDLL_OPEN) |-> fine_delay == $past(fine_set_q))
    else $error("open loop fine delay differs from setpoint");
  a_bw_field_write: assert property (
    hit(BANDWIDTH_OFS) |=> tracking_speed_q == $past(reg_wdata[1:0])
      && phase_filter_bandwidth_q == $past(reg_wdata[4:2]))
    else $error("bandwidth register write lost");
  a_snap_only_edge: assert property (
    !(hit(SNAP_REQ_OFS) && reg_wdata[0] && !snap_req_q) |=> $stable(fine_delay_snapshot_q)
      && $stable(phase_snapshot_q))
    else $error("snapshot changed without rising request");
  a_snap_on_edge: assert property (
    hit(SNAP_REQ_OFS) && reg_wdata[0] && !snap_req_q |=>
      fine_delay_snapshot_q == $past(fine_delay))
    else $error("snapshot missed rising request");
  a_coarse_snap_ro: assert property (
    hit(COARSE_SNAP_OFS) |=> $stable(coarse_delay_snapshot_q))
    else $error("coarse snapshot took a write");
  a_fine_snap_ro: assert property (
    hit(FINE_SNAP_OFS) |=> $stable(fine_delay_snapshot_q))
    else $error("fine snapshot took a write");
  a_core_invert: assert property (
    $changed(invert_core_clock) |-> core_clk_out == $past(core_clk_out))
    else $error("core clock polarity wrong");
  a_shape_write: assert property (
    hit(CLK_SHAPE_OFS) |=> core_clock_duty_correct == $past(reg_wdata[1])
      && core_clock_cross_ctrl == $past(reg_wdata[0]))
    else $error("clock shaping write lost");
  a_test_gated: assert property (
    !test_en_q ##1 !test_en_q |-> !test_clk_out)
    else $error("test clock running while disabled");
  a_test_div: assert property (
    test_en_q |=> test_clk_out == $past(div_cnt_q[test_div_q]))
    else $error("test clock divide wrong");
  a_loop_open: assert property (
    !loop_en_q ##1 !loop_en_q |-> state_q == DCDLL_OPEN && !loop_locked_flag)
    else $error("loop active while disabled");
  a_lock_flag: assert property (
    $rose(loop_locked_flag) |-> $past(state_q) == DCDLL_TRACK
      && $past(phase_filt_q) == $past(phase_target_q))
    else $error("lock flag set without phase match");
  a_phase_range: assert property (
    phase_target_q <= PHASE_MAX)
    else $error("target phase above maximum");

  c_lock_reached:  cover property ($rose(loop_locked_flag));
  c_snap_taken:    cover property (hit(SNAP_REQ_OFS) && reg_wdata[0] && !snap_req_q);
  c_test_div_max:  cover property (test_en_q && test_div_q == 2'h3 ##1 test_clk_out);
  c_lock_dropped:  cover property (loop_locked_flag ##1 !loop_en_q);

endmodule // dcdll_core

// ===== shared/dcdll_pkg.sv
package dcdll_pkg;
  localparam logic [11:0] LOOP_CTRL_OFS      = 12'h091;
  localparam logic [11:0] LOOP_STATUS_OFS    = 12'h092;
  localparam logic [11:0] COARSE_SET_OFS     = 12'h094;
  localparam logic [11:0] FINE_SET_OFS       = 12'h095;
  localparam logic [11:0] PHASE_TGT_OFS      = 12'h096;
  localparam logic [11:0] BANDWIDTH_OFS      = 12'h097;
  localparam logic [11:0] SNAP_REQ_OFS       = 12'h098;
  localparam logic [11:0] COARSE_SNAP_OFS    = 12'h099;
  localparam logic [11:0] FINE_SNAP_OFS      = 12'h09a;
  localparam logic [11:0] PHASE_SNAP_OFS     = 12'h09b;
  localparam logic [11:0] CLK_SHAPE_OFS      = 12'h09d;
  localparam logic [11:0] TEST_CLK_OFS       = 12'h0a0;
  localparam logic [7:0]  FINE_SET_RST       = 8'h80;
  localparam logic [4:0]  PHASE_TGT_RST      = 5'h08;
  localparam logic [4:0]  PHASE_MIN          = 5'h00;
  localparam logic [4:0]  PHASE_MAX          = 5'h10;
  localparam logic [2:0]  CLK_SHAPE_RST      = 3'h3;
  localparam int          INVERT_BIT         = 2;
  localparam int          DUTY_BIT           = 1;
  localparam int          CROSS_BIT          = 0;
  localparam int          TEST_EN_BIT        = 7;
  localparam int          BW_FILT_LSB        = 2;
  localparam logic [7:0]  TRACK_BASE_CYCLES  = 8'h08;
  localparam logic [3:0]  LOCK_HOLD_TICKS    = 4'h4;
  typedef enum logic [1:0] {
    DCDLL_OPEN  = 2'b00,
    DCDLL_TRACK = 2'b01,
    DCDLL_LOCK  = 2'b11
  } dcdll_state_t;
endpackage

// ===== test/dcdll_core_test.sv
`timescale 1ns/100ps
module dcdll_core_test;
  import dcdll_pkg::*;
  logic        mclk;
  logic        nrst;
  logic [11:0] reg_addr;
  logic [7:0]  reg_wdata;
  logic        reg_wr;
  logic [7:0]  reg_rdata;
  logic [4:0]  phase_meas;
  logic [5:0]  coarse_delay;
  logic [7:0]  fine_delay;
  logic        invert_core_clock;
  logic        core_clock_duty_correct;
  logic        core_clock_cross_ctrl;
  logic        core_clk_out;
  logic        test_clk_out;
  logic        loop_locked_flag;
  int          error_cnt;
  int          num_checks;
  logic [7:0]  tr;
  logic        prev;
  logic [11:0] ra [11] = '{12'h095, 12'h096, 12'h097, 12'h098, 12'h099, 12'h09a,
                           12'h09b, 12'h09d, 12'h0a0, 12'h092, 12'h0ff};
  logic [7:0]  rv [11] = '{8'h80, 8'h08, 8'h00, 8'h00, 8'h00, 8'h00,
                           8'h00, 8'h03, 8'h00, 8'h00, 8'h00};

  dcdll_core i_dcdll_core (
    .mclk(mclk), .nrst(nrst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rdata(reg_rdata), .phase_meas(phase_meas),
    .coarse_delay(coarse_delay), .fine_delay(fine_delay),
    .invert_core_clock(invert_core_clock), .core_clock_duty_correct(core_clock_duty_correct),
    .core_clock_cross_ctrl(core_clock_cross_ctrl), .core_clk_out(core_clk_out),
    .test_clk_out(test_clk_out), .loop_locked_flag(loop_locked_flag));

  initial begin
    mclk = 1'b0;
    forever #2.5 mclk = ~mclk;
  end

  task automatic finish_test();
    $display("Checks %0d errors %0d", num_checks, error_cnt);
    if (error_cnt == 0 && num_checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  task automatic chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
    num_checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("[ERR] %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  // One write, taken at the second edge
  task automatic wr(input logic [11:0] a, input logic [7:0] d);
    @(posedge mclk);
    #1;
    reg_addr  = a;
    reg_wdata = d;
    reg_wr    = 1'b1;
    @(posedge mclk);
    #1;
    reg_wr = 1'b0;
  endtask

  task automatic rd(input logic [11:0] a, input logic [7:0] e);
    @(posedge mclk);
    #1;
    reg_addr = a;
    #1;
    chk($sformatf("reg %h", a), reg_rdata, e);
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge mclk);
    #1;
  endtask

  // Bounded wait for the lock flag
  task automatic wait_lock();
    int i;
    for (i = 0; i < 400 && loop_locked_flag !== 1'b1; i++) begin
      cyc(1);
    end
    if (loop_locked_flag !== 1'b1) begin
      chk("lock wait", {7'h0, loop_locked_flag}, 8'h01);
    end
  endtask

  initial begin
    nrst = 1'b0; reg_addr = '0; reg_wdata = '0; reg_wr = 1'b0; phase_meas = 5'h0c;
    error_cnt = 0; num_checks = 0;
    cyc(6);
    nrst = 1'b1;
    // Reset values and outputs
    for (int k = 0; k < 11; k++) begin
      rd(ra[k], rv[k]);
    end
    chk("fine", fine_delay, 8'h80);
    chk("shape", {5'h0, invert_core_clock, core_clock_duty_correct, core_clock_cross_ctrl},
        8'h03);
    chk("test clk", {7'h0, test_clk_out}, 8'h00);
    // Writable fields, reserved bits, clamp, read-only places
    wr(FINE_SET_OFS, 8'hff); rd(FINE_SET_OFS, 8'hff);
    chk("fine", fine_delay, 8'hff);
    wr(BANDWIDTH_OFS, 8'hff); rd(BANDWIDTH_OFS, 8'h1f);
    wr(PHASE_TGT_OFS, 8'h1f); rd(PHASE_TGT_OFS, 8'h10);
    wr(PHASE_TGT_OFS, 8'h00); rd(PHASE_TGT_OFS, 8'h00);
    wr(COARSE_SNAP_OFS, 8'hff); rd(COARSE_SNAP_OFS, 8'h00);
    wr(FINE_SNAP_OFS, 8'hff); rd(FINE_SNAP_OFS, 8'h00);
    wr(CLK_SHAPE_OFS, 8'hff); rd(CLK_SHAPE_OFS, 8'h07);
    chk("shape", {5'h0, invert_core_clock, core_clock_duty_correct, core_clock_cross_ctrl},
        8'h07);
    wr(CLK_SHAPE_OFS, 8'h00);
    chk("shape", {5'h0, invert_core_clock, core_clock_duty_correct, core_clock_cross_ctrl},
        8'h00);
    // Inversion flips the core clock at the same parity
    prev = core_clk_out;
    wr(CLK_SHAPE_OFS, 8'h04);
    chk("core clk", {7'h0, core_clk_out}, {7'h0, ~prev});
    wr(TEST_CLK_OFS, 8'hff); rd(TEST_CLK_OFS, 8'h83);
    // Test output ratios 2,4,8,16 and disabled
    for (int d = 0; d < 5; d++) begin
      wr(TEST_CLK_OFS, (d < 4) ? (8'h80 | 8'(d)) : 8'h00);
      cyc(20);
      prev = test_clk_out;
      tr = '0;
      repeat (64) begin
        cyc(1);
        if (test_clk_out !== prev) tr++;
        prev = test_clk_out;
      end
      chk("test transitions", tr, (d < 4) ? (8'd64 >> d) : 8'd0);
    end
    chk("test clk", {7'h0, test_clk_out}, 8'h00);
    // Snapshot only on a rising request
    wr(BANDWIDTH_OFS, 8'h00);
    wr(COARSE_SET_OFS, 8'h2b);
    wr(FINE_SET_OFS, 8'h5a);
    cyc(8);
    wr(SNAP_REQ_OFS, 8'h01);
    rd(COARSE_SNAP_OFS, 8'h2b);
    rd(FINE_SNAP_OFS, 8'h5a);
    rd(PHASE_SNAP_OFS, 8'h0c);
    rd(SNAP_REQ_OFS, 8'h01);
    chk("coarse", {2'h0, coarse_delay}, 8'h2b);
    wr(FINE_SET_OFS, 8'h11);
    wr(SNAP_REQ_OFS, 8'h01); rd(FINE_SNAP_OFS, 8'h5a);
    wr(SNAP_REQ_OFS, 8'h00); rd(FINE_SNAP_OFS, 8'h5a);
    wr(SNAP_REQ_OFS, 8'h01); rd(FINE_SNAP_OFS, 8'h11);
    // Loop closed with a phase error: fine moves, no lock
    wr(PHASE_TGT_OFS, 8'h08);
    wr(LOOP_CTRL_OFS, 8'h01);
    cyc(100);
    chk("fine moved", {7'h0, fine_delay != 8'h11}, 8'h01);
    chk("lock", {7'h0, loop_locked_flag}, 8'h00);
    wr(LOOP_CTRL_OFS, 8'h00);
    cyc(4);
    chk("fine", fine_delay, 8'h11);
    // Matching phase: lock, then release
    phase_meas = 5'h08;
    cyc(8);
    wr(LOOP_CTRL_OFS, 8'h01);
    wait_lock();
    rd(LOOP_STATUS_OFS, 8'h01);
    chk("fine", fine_delay, 8'h11);
    wr(LOOP_CTRL_OFS, 8'h00);
    cyc(4);
    chk("lock", {7'h0, loop_locked_flag}, 8'h00);
    // Filtered phase settles from 8 down to a lower measurement
    wr(BANDWIDTH_OFS, 8'h08);
    phase_meas = 5'h04;
    cyc(64);
    wr(SNAP_REQ_OFS, 8'h00);
    wr(SNAP_REQ_OFS, 8'h01);
    rd(PHASE_SNAP_OFS, 8'h04);
    finish_test();
  end
endmodule // dcdll_core_test
